// ---- inc/pwt_pkg.sv ----
// Constants, register map and types for the periodic wakeup timer.
package pwt_pkg;

  // Register indices on the byte-wide register port.
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_TRIM = 3'h1;
  localparam logic [2:0] ADDR_RATE_HI = 3'h2;
  localparam logic [2:0] ADDR_RATE_LO = 3'h3;

  // Field positions in periodic_timer_control.
  localparam int CTRL_CLK_SEL = 7;
  localparam int CTRL_WAVE_SEL = 4;
  localparam int CTRL_EXT_EN = 3;
  localparam int CTRL_RUN = 2;
  localparam int CTRL_IRQ_EN = 1;
  localparam int CTRL_FLAG = 0;

  // Field positions in rc_clock_trim.
  localparam int TRIM_LSB = 2;
  localparam int TRIM_MSB = 7;
  localparam int TRIM_W = TRIM_MSB - TRIM_LSB + 1;

  // Reset values.
  localparam logic CTRL_BIT_RESET = 1'b0;
  localparam logic [15:0] RATE_RESET = 16'h0000;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 6'h00;

  // Timing: system clock and nominal untrimmed autonomous RC clock.
  localparam int CLK_PERIOD_NS = 50;
  localparam int RC_PERIOD_NS = 50000;
  localparam int RC_DIV_NOM = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_TRIM_STEP = 10;
  localparam int GATE_RC_EDGES = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_GATE = 2'b01,
    ST_RUN = 2'b10
  } pwt_state_t;

  // Last tick index of a period: a period is 2*(rate+1) ticks.
  function automatic logic [16:0] period_last(input logic [15:0] rate);
    period_last = {rate, 1'b1};
  endfunction

endpackage

// ---- src/pwt_rc_osc.sv ----
// Trimmable autonomous RC clock, modelled as an enable pulse divider.
`timescale 1ns/1ps
`default_nettype none
module pwt_rc_osc #(
  parameter int DIV_NOM = pwt_pkg::RC_DIV_NOM,
  parameter int TRIM_STEP = pwt_pkg::RC_TRIM_STEP
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [pwt_pkg::TRIM_W-1:0] trim,
  output logic rc_tick
);

  logic [11:0] div_w;
  logic [11:0] cnt_r;

  // Higher signed trim shortens the period, so frequency rises monotonically.
  assign div_w = 12'(DIV_NOM - ($signed(trim) * TRIM_STEP)); // R12 R11

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 12'h000;
      rc_tick <= 1'b0;
    end else if (cnt_r >= div_w - 12'h001) begin
      cnt_r <= 12'h000;
      rc_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 12'h001;
      rc_tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ---- src/pwt_timer.sv ----
// Periodic wakeup timer top: registers, clock gating, period counter, pin.
//
// Contract
// R1: Bit 7 picks RC clock or bus clock.
// R2: Clock select writable only while timer stopped.
// R3: Bit 2 starts and stops the timer.
// R4: Timeout flag sets at each period end.
// R5: Flag clears on write one only.
// R6: Interrupt enable gates flag onto request.
// R7: External bit routes waveform only while running.
// R8: Pulse option: half-minimum-period pulse per period.
// R9: Clock option: square wave, twice period.
// R10: Bit 4 selects pulse or clock waveform.
// R11: Trim is six-bit signed in bits 7:2.
// R12: Trim raises RC frequency monotonically.
// R13: Trim loads from flash after reset.
// R14: Period is 2*(rate+1) counter clock ticks; on the RC clock the code counts RC/2, giving 4*(rate+1) RC periods.
// R15: Rate writable only while timer stopped.
// R16: RC start delayed two to three cycles.
// R17: Waveform select zero pulse, one clock.
// R18: Control bits and flag reset to zero.
`timescale 1ns/1ps
`default_nettype none
module pwt_timer #(
  parameter int RC_DIV_NOM = pwt_pkg::RC_DIV_NOM,
  parameter int RC_TRIM_STEP = pwt_pkg::RC_TRIM_STEP
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [pwt_pkg::TRIM_W-1:0] flash_trim,
  output logic timer_irq,
  output logic timer_wave_pin
);

  // Control register fields.
  logic timer_clock_select_r;
  logic waveform_select_r;
  logic waveform_external_enable_r;
  logic timer_run_enable_r;
  logic timeout_irq_enable_r;
  logic timeout_flag_r;

  logic [pwt_pkg::TRIM_W-1:0] rc_trim_value_r;
  logic trim_load_r;
  logic [15:0] period_rate_value_r;

  pwt_pkg::pwt_state_t state_r;
  pwt_pkg::pwt_state_t state_nxt;
  logic [1:0] gate_cnt_r;
  logic half_r;
  logic [16:0] cnt_r;

  logic rc_tick;
  logic tick_w;
  logic bus_tick_w;
  logic rc_half_tick_w;
  logic [16:0] period_last_w;
  logic period_end_w;
  logic running_w;
  logic gate_done_w;
  logic wave_level;
  logic pin_route_w;
  logic wr_ctrl_w;
  logic wr_trim_w;
  logic wr_rate_hi_w;
  logic wr_rate_lo_w;
  logic flag_clear_w;
  logic clk_sel_open_w;
  logic [7:0] rd_mux_w;

  // True when the given strobe is high and the index matches.
  function automatic logic reg_hit(
    input logic strobe,
    input logic [2:0] addr,
    input logic [2:0] idx
  );
    reg_hit = strobe && (addr == idx);
  endfunction

  // Places the control fields at their bit positions; bits 6 and 5 read zero.
  function automatic logic [7:0] ctrl_image(
    input logic clk_sel,
    input logic wave_sel,
    input logic ext_en,
    input logic run,
    input logic irq_en,
    input logic flag
  );
    ctrl_image = 8'h00;
    ctrl_image[pwt_pkg::CTRL_CLK_SEL] = clk_sel;
    ctrl_image[pwt_pkg::CTRL_WAVE_SEL] = wave_sel;
    ctrl_image[pwt_pkg::CTRL_EXT_EN] = ext_en;
    ctrl_image[pwt_pkg::CTRL_RUN] = run;
    ctrl_image[pwt_pkg::CTRL_IRQ_EN] = irq_en;
    ctrl_image[pwt_pkg::CTRL_FLAG] = flag;
  endfunction

  assign wr_ctrl_w = reg_hit(reg_wr, reg_addr, pwt_pkg::ADDR_CTRL);
  assign wr_trim_w = reg_hit(reg_wr, reg_addr, pwt_pkg::ADDR_TRIM);
  assign wr_rate_hi_w = reg_hit(reg_wr, reg_addr, pwt_pkg::ADDR_RATE_HI);
  assign wr_rate_lo_w = reg_hit(reg_wr, reg_addr, pwt_pkg::ADDR_RATE_LO);
  assign flag_clear_w = wr_ctrl_w && reg_wdata[pwt_pkg::CTRL_FLAG]; // R5

  // Switching clocks under a running count would corrupt the period, so the
  // select is frozen while running and also on the write that starts it.
  assign clk_sel_open_w = wr_ctrl_w && !timer_run_enable_r && !reg_wdata[pwt_pkg::CTRL_RUN];

  // A stopped timer keeps the pin low even with the external bit set.
  assign pin_route_w = waveform_external_enable_r && timer_run_enable_r; // R7

  // Fields that software may change at any time except the clock select, which opens only while stopped; one register each.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      waveform_select_r <= pwt_pkg::CTRL_BIT_RESET; // R18
    end else if (wr_ctrl_w) begin
      waveform_select_r <= reg_wdata[pwt_pkg::CTRL_WAVE_SEL]; // R10
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      waveform_external_enable_r <= pwt_pkg::CTRL_BIT_RESET; // R18
    end else if (wr_ctrl_w) begin
      waveform_external_enable_r <= reg_wdata[pwt_pkg::CTRL_EXT_EN]; // R7
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timer_run_enable_r <= pwt_pkg::CTRL_BIT_RESET; // R18
    end else if (wr_ctrl_w) begin
      timer_run_enable_r <= reg_wdata[pwt_pkg::CTRL_RUN]; // R3
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timeout_irq_enable_r <= pwt_pkg::CTRL_BIT_RESET; // R18
    end else if (wr_ctrl_w) begin
      timeout_irq_enable_r <= reg_wdata[pwt_pkg::CTRL_IRQ_EN]; // R6
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timer_clock_select_r <= pwt_pkg::CTRL_BIT_RESET; // R18
    end else if (clk_sel_open_w) begin
      timer_clock_select_r <= reg_wdata[pwt_pkg::CTRL_CLK_SEL]; // R2 R1
    end
  end

  // A period end in the same cycle as a clearing write keeps the flag set.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timeout_flag_r <= pwt_pkg::CTRL_BIT_RESET; // R18
    end else if (period_end_w) begin
      timeout_flag_r <= 1'b1; // R4
    end else if (flag_clear_w) begin
      timeout_flag_r <= 1'b0; // R5
    end
  end

  // Rate bytes are ignored while the timer runs.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      period_rate_value_r <= pwt_pkg::RATE_RESET;
    end else if (!timer_run_enable_r) begin
      if (wr_rate_hi_w) begin
        period_rate_value_r[15:8] <= reg_wdata; // R15
      end
      if (wr_rate_lo_w) begin
        period_rate_value_r[7:0] <= reg_wdata; // R15
      end
    end
  end

  // The flash value is sampled on the first edge after reset release; the
  // register port is not expected to be used on that edge.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      trim_load_r <= 1'b1;
      rc_trim_value_r <= pwt_pkg::TRIM_RESET;
    end else if (trim_load_r) begin
      trim_load_r <= 1'b0;
      rc_trim_value_r <= flash_trim; // R13
    end else if (wr_trim_w) begin
      rc_trim_value_r <= reg_wdata[pwt_pkg::TRIM_MSB:pwt_pkg::TRIM_LSB]; // R11
    end
  end

  pwt_rc_osc #(
    .DIV_NOM(RC_DIV_NOM),
    .TRIM_STEP(RC_TRIM_STEP)
  ) u_rc_osc (
    .clock(clock),
    .reset_n(reset_n),
    .trim(rc_trim_value_r),
    .rc_tick(rc_tick)
  );

  // Run sequencing. The RC path waits for two RC edges, mimicking the
  // synchronous gate release; the phase of the RC clock adds up to one more.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pwt_pkg::ST_IDLE: begin
        if (timer_run_enable_r) begin
          state_nxt = timer_clock_select_r ? pwt_pkg::ST_RUN : pwt_pkg::ST_GATE; // R3
        end
      end
      pwt_pkg::ST_GATE: begin
        if (!timer_run_enable_r) begin
          state_nxt = pwt_pkg::ST_IDLE;
        end else if (gate_done_w) begin
          state_nxt = pwt_pkg::ST_RUN; // R16
        end
      end
      pwt_pkg::ST_RUN: begin
        if (!timer_run_enable_r) begin
          state_nxt = pwt_pkg::ST_IDLE; // R3
        end
      end
      default: begin
        state_nxt = pwt_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= pwt_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gate_cnt_r <= 2'h0;
    end else if (state_r != pwt_pkg::ST_GATE) begin
      gate_cnt_r <= 2'h0;
    end else if (rc_tick) begin
      gate_cnt_r <= gate_cnt_r + 2'h1; // R16
    end
  end

  // The RC path counts on the RC clock divided by two.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      half_r <= 1'b0;
    end else if (!running_w) begin
      half_r <= 1'b0;
    end else if (rc_tick) begin
      half_r <= ~half_r;
    end
  end

  // The gate opens on the RC edge that completes the release count.
  assign gate_done_w = rc_tick && (gate_cnt_r == 2'(pwt_pkg::GATE_RC_EDGES - 1)); // R16
  assign running_w = (state_r == pwt_pkg::ST_RUN);

  // The bus path ticks every cycle; an RC tick spans two RC periods, which
  // halves the resolution of RC periods in exchange for a symmetric pulse.
  assign bus_tick_w = timer_clock_select_r; // R1
  assign rc_half_tick_w = rc_tick && half_r;
  assign tick_w = running_w && (bus_tick_w || rc_half_tick_w); // R1 R14

  assign period_last_w = pwt_pkg::period_last(period_rate_value_r);
  assign period_end_w = tick_w && (cnt_r == period_last_w); // R14

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= 17'h00000;
    end else if (!running_w) begin
      cnt_r <= 17'h00000;
    end else if (period_end_w) begin
      cnt_r <= 17'h00000; // R14
    end else if (tick_w) begin
      cnt_r <= cnt_r + 17'h00001;
    end
  end

  pwt_wave_gen u_wave_gen (
    .clock(clock),
    .reset_n(reset_n),
    .active(running_w),
    .tick(tick_w),
    .period_end(period_end_w),
    .wave_sel(waveform_select_r),
    .wave_level(wave_level)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timer_wave_pin <= 1'b0;
    end else begin
      timer_wave_pin <= pin_route_w && wave_level; // R7
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= timeout_irq_enable_r && timeout_flag_r; // R6
    end
  end

  // Unused bits and unmapped addresses read as zero.
  always_comb begin
    rd_mux_w = 8'h00;
    case (reg_addr)
      pwt_pkg::ADDR_CTRL: begin
        rd_mux_w = ctrl_image(timer_clock_select_r, waveform_select_r,
                              waveform_external_enable_r, timer_run_enable_r,
                              timeout_irq_enable_r, timeout_flag_r);
      end
      pwt_pkg::ADDR_TRIM: begin
        rd_mux_w[pwt_pkg::TRIM_MSB:pwt_pkg::TRIM_LSB] = rc_trim_value_r;
      end
      pwt_pkg::ADDR_RATE_HI: begin
        rd_mux_w = period_rate_value_r[15:8];
      end
      pwt_pkg::ADDR_RATE_LO: begin
        rd_mux_w = period_rate_value_r[7:0];
      end
      default: begin
        rd_mux_w = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux_w;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule
`default_nettype wire

// ---- src/pwt_wave_gen.sv ----
// Pulse or square-clock waveform built from timer ticks and period ends.
`timescale 1ns/1ps
`default_nettype none
module pwt_wave_gen (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic active,
  input wire logic tick,
  input wire logic period_end,
  input wire logic wave_sel,
  output logic wave_level
);

  logic pulse_r;
  logic square_r;

  // The pulse spans one tick, which is half of the shortest period.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pulse_r <= 1'b0;
    end else if (!active) begin
      pulse_r <= 1'b0;
    end else if (period_end) begin
      pulse_r <= 1'b1; // R8
    end else if (tick) begin
      pulse_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      square_r <= 1'b0;
    end else if (!active) begin
      square_r <= 1'b0;
    end else if (period_end) begin
      square_r <= ~square_r; // R9
    end
  end

  assign wave_level = wave_sel ? square_r : pulse_r; // R10 R17

endmodule
`default_nettype wire

// ---- testbench/pwt_timer_props.sv ----
// Port-level checker for the periodic wakeup timer.
`timescale 1ns/1ps
`default_nettype none
module pwt_timer_props #(
  parameter int RC_DIV_NOM = pwt_pkg::RC_DIV_NOM,
  parameter int RC_TRIM_STEP = pwt_pkg::RC_TRIM_STEP
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [pwt_pkg::TRIM_W-1:0] flash_trim,
  input wire logic timer_irq,
  input wire logic timer_wave_pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Shadow of what software has written, so outputs can be tied to it.
  logic run_r, en_r, ext_r, ws_r, bus_r, c0, route, r0;
  logic [15:0] rate_r;
  assign c0 = reg_wr && reg_addr == pwt_pkg::ADDR_CTRL;
  assign route = run_r && ext_r;
  assign r0 = rate_r == 16'h0000;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      {run_r, en_r, ext_r, ws_r} <= 4'h0;
    end else if (c0) begin
      {ws_r, ext_r, run_r, en_r} <= reg_wdata[4:1];
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bus_r <= 1'b0;
    end else if (c0 && !run_r && !reg_wdata[2]) begin
      bus_r <= reg_wdata[7];
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rate_r <= 16'h0000;
    end else if (reg_wr && !run_r && reg_addr == pwt_pkg::ADDR_RATE_HI) begin
      rate_r[15:8] <= reg_wdata;
    end else if (reg_wr && !run_r && reg_addr == pwt_pkg::ADDR_RATE_LO) begin
      rate_r[7:0] <= reg_wdata;
    end
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside the read answer cycle");
  a_trim_low_zero: assert property (
    reg_rd && reg_addr == pwt_pkg::ADDR_TRIM |=> reg_rdata[1:0] == 2'h0)
    else $error("trim low bits not zero");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 3'h3 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_gated: assert property (!$past(en_r) |-> !timer_irq)
    else $error("interrupt request while disabled");
  a_pin_routed: assert property (
    !route && !$past(route) && !$past(route, 2) && !$past(route, 3) |-> !timer_wave_pin)
    else $error("pin active without external enable and run");
  a_pulse_bus: assert property (
    $rose(timer_wave_pin) && bus_r && !ws_r && r0 |=> !timer_wave_pin ##1 (timer_wave_pin || !route))
    else $error("pulse shape wrong on bus clock");
  a_clock_bus: assert property (
    $rose(timer_wave_pin) && bus_r && ws_r && r0 |-> timer_wave_pin[*2] ##1 (!timer_wave_pin || !route))
    else $error("clock wave shape wrong on bus clock");
  a_first_timeout: assert property (
    c0 && reg_wdata[2:0] == 3'h7 && !run_r && !en_r && bus_r && r0 |-> !timer_irq[*5] ##1 timer_irq)
    else $error("first timeout not at the expected cycle");
endmodule
bind pwt_timer pwt_timer_props #(.RC_DIV_NOM(RC_DIV_NOM), .RC_TRIM_STEP(RC_TRIM_STEP)) u_props (
  .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_trim(flash_trim),
  .timer_irq(timer_irq), .timer_wave_pin(timer_wave_pin));
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking testbench for the periodic wakeup timer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // A short RC divider keeps the autonomous clock runs brief.
  localparam int DIV = 40;
  localparam logic [5:0] TV [3] = '{6'h20, 6'h00, 6'h1F};
  logic clock, reset_n, reg_wr, reg_rd, timer_irq, timer_wave_pin;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_v;
  logic [5:0] flash_trim;
  int num_errors, check_count;
  pwt_timer #(.RC_DIV_NOM(DIV), .RC_TRIM_STEP(1)) dut (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_trim(flash_trim),
    .timer_irq(timer_irq), .timer_wave_pin(timer_wave_pin));
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    rd_v = reg_rdata;
    chk(what, {8'h00, e}, {8'h00, rd_v});
  endtask
  task automatic rises(input int n, output int c);
    logic p;
    c = 0;
    p = timer_wave_pin;
    repeat (n) begin
      @(negedge clock);
      if (timer_wave_pin === 1'b1 && p === 1'b0) c++;
      p = timer_wave_pin;
    end
  endtask
  task automatic wait_pin(output int n);
    logic v;
    n = 0;
    v = timer_wave_pin;
    while (timer_wave_pin === v && n < 2000) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic t_reset;
    rchk("ctrl", pwt_pkg::ADDR_CTRL, 8'h00);
    rchk("trim", pwt_pkg::ADDR_TRIM, {6'h15, 2'h0});
    rchk("rate_hi", pwt_pkg::ADDR_RATE_HI, 8'h00);
    rchk("unmapped", 3'h7, 8'h00);
    chk("irq", 16'h0000, {15'h0000, timer_irq});
  endtask
  task automatic t_regs;
    wr(pwt_pkg::ADDR_RATE_HI, 8'h12);
    wr(pwt_pkg::ADDR_RATE_LO, 8'h34);
    rchk("rate_lo", pwt_pkg::ADDR_RATE_LO, 8'h34);
    wr(pwt_pkg::ADDR_TRIM, 8'hFF);
    rchk("trim", pwt_pkg::ADDR_TRIM, 8'hFC);
    wr(pwt_pkg::ADDR_CTRL, 8'h84);
    rchk("ctrl", pwt_pkg::ADDR_CTRL, 8'h04);
    wr(pwt_pkg::ADDR_RATE_HI, 8'hAB);
    rchk("rate_hi", pwt_pkg::ADDR_RATE_HI, 8'h12);
    wr(pwt_pkg::ADDR_CTRL, 8'h00);
    wr(pwt_pkg::ADDR_CTRL, 8'h80);
    rchk("ctrl", pwt_pkg::ADDR_CTRL, 8'h80);
    wr(pwt_pkg::ADDR_CTRL, 8'h84);
    wr(pwt_pkg::ADDR_CTRL, 8'h00);
    rchk("ctrl", pwt_pkg::ADDR_CTRL, 8'h80);
  endtask
  task automatic t_flag;
    int n;
    wr(pwt_pkg::ADDR_RATE_HI, 8'h00);
    wr(pwt_pkg::ADDR_RATE_LO, 8'h00);
    wr(pwt_pkg::ADDR_CTRL, 8'h87);
    n = 0;
    while (timer_irq !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    chk("irq", 16'h0001, {15'h0000, timer_irq});
    wr(pwt_pkg::ADDR_CTRL, 8'h84);
    rchk("ctrl", pwt_pkg::ADDR_CTRL, 8'h85);
    chk("irq", 16'h0000, {15'h0000, timer_irq});
    wr(pwt_pkg::ADDR_CTRL, 8'h82);
    wr(pwt_pkg::ADDR_CTRL, 8'h83);
    repeat (20) @(negedge clock);
    rchk("ctrl", pwt_pkg::ADDR_CTRL, 8'h82);
    chk("irq", 16'h0000, {15'h0000, timer_irq});
  endtask
  task automatic t_wave_bus;
    int c;
    wr(pwt_pkg::ADDR_CTRL, 8'h8C);
    repeat (6) @(negedge clock);
    rises(20, c);
    chk("pulses", 16'h000A, c[15:0]);
    wr(pwt_pkg::ADDR_CTRL, 8'h80);
    wr(pwt_pkg::ADDR_CTRL, 8'h9C);
    repeat (6) @(negedge clock);
    rises(20, c);
    chk("clock_edges", 16'h0005, c[15:0]);
    wr(pwt_pkg::ADDR_CTRL, 8'h94);
    repeat (6) @(negedge clock);
    rises(20, c);
    chk("hidden_edges", 16'h0000, c[15:0]);
    wr(pwt_pkg::ADDR_CTRL, 8'h80);
    wr(pwt_pkg::ADDR_RATE_LO, 8'h02);
    wr(pwt_pkg::ADDR_CTRL, 8'h9C);
    wait_pin(c);
    wait_pin(c);
    chk("rate2_period", 16'h0006, c[15:0]);
    wr(pwt_pkg::ADDR_CTRL, 8'h80);
    wr(pwt_pkg::ADDR_RATE_LO, 8'h00);
    wr(pwt_pkg::ADDR_CTRL, 8'h01);
    rchk("ctrl", pwt_pkg::ADDR_CTRL, 8'h00);
  endtask
  task automatic t_rc_trim;
    int n, e;
    for (int i = 0; i < 3; i++) begin
      wr(pwt_pkg::ADDR_TRIM, {TV[i], 2'h0});
      wr(pwt_pkg::ADDR_CTRL, 8'h1C);
      wait_pin(n);
      wait_pin(n);
      e = 4 * (DIV - $signed(TV[i]));
      chk("rc_period", e[15:0], n[15:0]);
      wr(pwt_pkg::ADDR_CTRL, 8'h01);
      repeat (4) @(negedge clock);
    end
  endtask
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    #(50 * 40000);
    num_errors++;
    finish_test;
  end
  initial begin
    {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    flash_trim = 6'h15;
    num_errors = 0;
    check_count = 0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset;
    t_regs;
    t_flag;
    t_wave_bus;
    t_rc_trim;
    finish_test;
  end
endmodule
`default_nettype wire
